// *** hw/pfw_ctrl.sv ***
// Program flash self-write controller with APB register access.
//
// Contract
// - Firmware reads and writes flash through registers.
// - Data pair carries one 14-bit word.
// - Address pair holds 15-bit word address.
// - Internal timer sets program/erase duration.
// - Code protect blocks external programmer only.
// - Bulk erase or system reset removes code protection.
// - Write-protect region refuses self-write and erase.
// - Start bits set-only, hardware clears them.
// - Writes need write enable gate, reset clear.
// - Reset during write sets abort flag.
// - Unlock key register reads as zero.
// - Unlock pattern required before latch/array writes.
// - Row erase of 16 words, 16 latches.
// - Hidden 14-bit latches loaded via data pair.
// - Unprogrammed words programmable without erase.
// - Pattern 55h then AAh right before start.
// - Read fetch takes second cycle, data held.
// - Low address bits pick latch, row aligned.
// - Latches return to 3FFF after write.
module pfw_ctrl
   import pfw_pkg::*;
#(
   parameter int ERASE_CYCLES = ERASE_CYC,
   parameter int MEM_WORDS    = 2048
)
(
   input  wire logic              ref_clk,      // System clock, 125 MHz.
   input  wire logic              sys_rst,      // Async reset, active high.
   input  wire logic              por_n,        // Power-on reset, active low.
   input  wire logic              psel,         // APB select.
   input  wire logic              penable,      // APB access phase.
   input  wire logic              pwrite,       // APB direction.
   input  wire logic [7:0]        paddr,        // APB byte address.
   input  wire logic [31:0]       pwdata,       // APB write data.
   output logic [31:0]            prdata,       // APB read data.
   output logic                   pready,       // APB ready.
   output logic                   pslverr,      // APB error, unmapped.
   input  wire logic              code_protect_n, // Config, 0 = protected.
   input  wire logic [1:0]        write_protect_region, // Config field.
   input  wire logic              prog_bulk_erase, // Programmer bulk erase.
   output logic                   cpu_stall,    // Core stalled by flash.
   output logic                   ext_access_ok // Programmer may access.
);

   typedef struct packed
   {
      pfw_state_type         st;
      pfw_key_type           key;
      logic [ADDR_W-1:0]     addr;
      logic [DATA_W-1:0]     data;
      logic                  rd;
      logic                  wr;
      logic                  write_enable_gate;
      logic                  werr;
      logic                  free;
      logic                  lwlo;
      logic                  cfgs;
      logic                  wrArmed;
      logic                  cp;
      logic [1:0]            cnt;
      logic                  tmrGo;
      logic [31:0]           rdat;
      logic                  rdy;
      logic                  err;
      logic                  stall;
      logic                  extOk;
   } pfw_ctrl_type;

   pfw_ctrl_type cur_ff;
   pfw_ctrl_type nxt_cur;

   // Flash array and write latches; separate from the struct because
   // they are memories rather than control state.
   logic [DATA_W-1:0] mem_ff   [MEM_WORDS];
   logic [DATA_W-1:0] latch_ff [LATCH_N];
   logic              tmrDone;
   logic              cfgSync1_ff;
   logic              cfgSync2_ff;
   logic              bulkSync1_ff;
   logic              bulkSync2_ff;
   logic              porSync1_ff;
   logic              porSeen_ff;
   logic              wasBusy_ff;

   // ****
   // Program/erase timer
   // ****
   pfw_timer #(.CYCLES(ERASE_CYCLES)) u_timer
   (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .start   (cur_ff.tmrGo),
      .done    (tmrDone)
   );

   // Code-protect, bulk-erase and power-on pins pass two flip-flops before use.
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cfgSync1_ff  <= 1'b1;
         cfgSync2_ff  <= 1'b1;
         bulkSync1_ff <= 1'b0;
         bulkSync2_ff <= 1'b0;
         porSync1_ff  <= 1'b1;
         porSeen_ff   <= 1'b1;
      end
      else
      begin
         cfgSync1_ff  <= code_protect_n;
         cfgSync2_ff  <= cfgSync1_ff;
         bulkSync1_ff <= prog_bulk_erase;
         bulkSync2_ff <= bulkSync1_ff;
         porSync1_ff  <= por_n;
         porSeen_ff   <= porSync1_ff;
      end
   end

   // Word index within the array, row base and protection decision.
   logic [ADDR_W-1:0] rowBase;
   logic              wrtBlock;
   logic              apbWr;
   logic              apbRd;
   logic [ADDR_W-1:0] hiAddr;
   assign rowBase = {cur_ff.addr[ADDR_W-1:LATCH_AW], {LATCH_AW{1'b0}}};
   assign apbWr   = psel && penable && pwrite && !cur_ff.rdy;
   assign apbRd   = psel && penable && !pwrite && !cur_ff.rdy;
   assign hiAddr  = 15'(MEM_WORDS / 2);

   // Write protection: full, upper half free, low quarter, or none.
   always_comb
   begin
      unique case (write_protect_region)
         WRT_OFF:  wrtBlock = 1'b0;
         WRT_LOW:  wrtBlock = cur_ff.addr < 15'(MEM_WORDS / 4);
         WRT_HALF: wrtBlock = cur_ff.addr < hiAddr;
         default:  wrtBlock = 1'b1;
      endcase
   end

   // ****
   // Register access and sequencer
   // ****
   always_comb
   begin
      nxt_cur       = cur_ff;
      nxt_cur.tmrGo = 1'b0;
      nxt_cur.rdy   = 1'b0;
      nxt_cur.err   = 1'b0;
      nxt_cur.rdat  = 32'h0000_0000;
      nxt_cur.extOk = cur_ff.cp;
      if (wasBusy_ff && cur_ff.st == ST_IDLE)
         nxt_cur.werr = 1'b1;
      // Protection latches on; a bulk erase or sys_rst removes it.
      if (bulkSync2_ff)
         nxt_cur.cp = 1'b1;
      else if (!cfgSync2_ff)
         nxt_cur.cp = 1'b0;
      // APB answers one cycle after the access phase starts.
      if (psel && penable && !cur_ff.rdy)
      begin
         nxt_cur.rdy = 1'b1;
         unique case (paddr)
            FLASH_ADDR_LOW_OFS:
            begin
               if (pwrite)
                  nxt_cur.addr[7:0] = pwdata[7:0];
               nxt_cur.rdat = {24'h00_0000, cur_ff.addr[7:0]};
            end
            FLASH_ADDR_HIGH_OFS:
            begin
               if (pwrite)
                  nxt_cur.addr[ADDR_W-1:8] = pwdata[6:0];
               nxt_cur.rdat = {25'h000_0000, cur_ff.addr[ADDR_W-1:8]};
            end
            FLASH_DATA_LOW_OFS:
            begin
               if (pwrite)
                  nxt_cur.data[7:0] = pwdata[7:0];
               nxt_cur.rdat = {24'h00_0000, cur_ff.data[7:0]};
            end
            FLASH_DATA_HIGH_OFS:
            begin
               if (pwrite)
                  nxt_cur.data[DATA_W-1:8] = pwdata[5:0];
               nxt_cur.rdat = {26'h000_0000, cur_ff.data[DATA_W-1:8]};
            end
            FLASH_CONTROL_OFS:
            begin
               if (pwrite && cur_ff.st == ST_IDLE)
               begin
                  // Start bits can only be set here; clears are lost.
                  if (pwdata[CTL_RD_BIT])
                     nxt_cur.rd = 1'b1;
                  if (pwdata[CTL_WR_BIT])
                     nxt_cur.wr = 1'b1;
                  nxt_cur.write_enable_gate = pwdata[CTL_WRITE_ENABLE_GATE_BIT];
                  nxt_cur.free = pwdata[CTL_FREE_BIT];
                  nxt_cur.lwlo = pwdata[CTL_LWLO_BIT];
                  nxt_cur.cfgs = pwdata[CTL_CFGS_BIT];
                  if (!pwdata[CTL_WERR_BIT])
                     nxt_cur.werr = 1'b0;
                  // Arming requires the key sequence just completed.
                  nxt_cur.wrArmed = pwdata[CTL_WR_BIT]
                     && cur_ff.key == KY_OPEN;
                  nxt_cur.key = KY_NONE;
               end
               nxt_cur.rdat = 32'({cur_ff.cfgs, cur_ff.lwlo,
                  cur_ff.free, cur_ff.werr, cur_ff.write_enable_gate,
                  cur_ff.wr, cur_ff.rd});
            end
            UNLOCK_KEY_OFS:
            begin
               // Any other write in between, except a control write while not idle, breaks the sequence.
               if (pwrite)
               begin
                  if (pwdata[7:0] == KEY_FIRST)
                     nxt_cur.key = KY_FIRST;
                  else if (pwdata[7:0] == KEY_SECOND
                           && cur_ff.key == KY_FIRST)
                     nxt_cur.key = KY_OPEN;
                  else
                     nxt_cur.key = KY_NONE;
               end
               nxt_cur.rdat = 32'h0000_0000;
            end
            FLASH_CONFIG_OFS:
               nxt_cur.rdat = 32'({write_protect_region, cur_ff.cp,
                  cur_ff.st});
            default:
               nxt_cur.err = 1'b1;
         endcase
         if (pwrite && paddr != UNLOCK_KEY_OFS
             && paddr != FLASH_CONTROL_OFS)
            nxt_cur.key = KY_NONE;
      end

      // Sequencer: the core is stalled while a cycle runs.
      unique case (cur_ff.st)
         ST_IDLE:
         begin
            if (cur_ff.rd)
            begin
               nxt_cur.st    = ST_READ;
               nxt_cur.cnt   = 2'(READ_CYC - 1);
               nxt_cur.stall = 1'b1;
            end
            else if (cur_ff.wr)
            begin
               if (!cur_ff.wrArmed || !cur_ff.write_enable_gate || wrtBlock)
                  nxt_cur.wr = 1'b0;
               else if (cur_ff.free || !cur_ff.lwlo)
               begin
                  nxt_cur.st    = cur_ff.free ? ST_ERASE : ST_PROG;
                  nxt_cur.tmrGo = 1'b1;
                  nxt_cur.stall = 1'b1;
               end
               else
                  nxt_cur.wr = 1'b0;
               nxt_cur.wrArmed = 1'b0;
            end
         end
         ST_READ:
         begin
            if (cur_ff.cnt == 2'h0)
            begin
               nxt_cur.data  = mem_ff[cur_ff.addr[10:0]];
               nxt_cur.rd    = 1'b0;
               nxt_cur.stall = 1'b0;
               nxt_cur.st    = ST_IDLE;
            end
            else
               nxt_cur.cnt = cur_ff.cnt - 2'h1;
         end
         ST_ERASE, ST_PROG:
            if (tmrDone)
               nxt_cur.st = ST_CLEAR;
         ST_CLEAR:
         begin
            nxt_cur.wr    = 1'b0;
            nxt_cur.stall = 1'b0;
            nxt_cur.st    = ST_IDLE;
         end
         default:
            nxt_cur.st = ST_IDLE;
      endcase
   end

   // Latch load happens on an armed write with the load-only bit set.
   logic latchLoad;
   assign latchLoad = cur_ff.st == ST_IDLE && cur_ff.wr && cur_ff.wrArmed
      && cur_ff.write_enable_gate && !wrtBlock && cur_ff.lwlo && !cur_ff.free;

   // ****
   // State register
   // ****
   // Reset loads constants only; the abort flag is set after it.
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cur_ff    <= '0;
         cur_ff.cp <= 1'b1;
      end
      else
      begin
         cur_ff <= nxt_cur;
         if (!porSeen_ff)
         begin
            cur_ff.write_enable_gate <= 1'b0;
            cur_ff.werr <= 1'b0;
         end
      end
   end

   // ****
   // Array and latches
   // ****
   // No reset on the array, it models nonvolatile storage.
   always_ff @(posedge ref_clk)
   begin
      // Holds through reset, so a cut cycle is still known after it.
      if (!sys_rst)
         wasBusy_ff <= cur_ff.st == ST_ERASE || cur_ff.st == ST_PROG;
      if (bulkSync2_ff)
      begin
         for (int i = 0; i < MEM_WORDS; i++)
            mem_ff[i] <= ERASED_WORD;
      end
      else if (cur_ff.st == ST_ERASE && tmrDone)
      begin
         for (int i = 0; i < LATCH_N; i++)
            mem_ff[11'(rowBase) + 11'(i)] <= ERASED_WORD;
      end
      else if (cur_ff.st == ST_PROG && tmrDone)
      begin
         // Flash only clears bits, so blank words program directly.
         for (int i = 0; i < LATCH_N; i++)
            mem_ff[11'(rowBase) + 11'(i)] <=
               mem_ff[11'(rowBase) + 11'(i)] & latch_ff[i];
      end
   end

   // Write latches load from the data pair and reset after a write.
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < LATCH_N; i++)
            latch_ff[i] <= ERASED_WORD;
      end
      else if (cur_ff.st == ST_PROG && tmrDone)
      begin
         for (int i = 0; i < LATCH_N; i++)
            latch_ff[i] <= ERASED_WORD;
      end
      else if (latchLoad)
         latch_ff[cur_ff.addr[LATCH_AW-1:0]] <= cur_ff.data;
   end

   // Outputs straight from flip-flops.
   assign prdata        = cur_ff.rdat;
   assign pready        = cur_ff.rdy;
   assign pslverr       = cur_ff.err;
   assign cpu_stall     = cur_ff.stall;
   assign ext_access_ok = cur_ff.extOk;

endmodule : pfw_ctrl

// *** hw/pfw_pkg.sv ***
// Package of constants and types for the program flash self-write controller.
package pfw_pkg;

   // ****
   // Register map (APB byte addresses, one word per register)
   // ****
   localparam logic [7:0] FLASH_ADDR_LOW_OFS  = 8'h00;
   localparam logic [7:0] FLASH_ADDR_HIGH_OFS = 8'h04;
   localparam logic [7:0] FLASH_DATA_LOW_OFS  = 8'h08;
   localparam logic [7:0] FLASH_DATA_HIGH_OFS = 8'h0C;
   localparam logic [7:0] FLASH_CONTROL_OFS   = 8'h10;
   localparam logic [7:0] UNLOCK_KEY_OFS      = 8'h14;
   localparam logic [7:0] FLASH_CONFIG_OFS    = 8'h18;

   // ****
   // Field layout of the control register
   // ****
   localparam int CTL_RD_BIT   = 0;
   localparam int CTL_WR_BIT   = 1;
   localparam int CTL_WRITE_ENABLE_GATE_BIT = 2;
   localparam int CTL_WERR_BIT = 3;
   localparam int CTL_FREE_BIT = 4;
   localparam int CTL_LWLO_BIT = 5;
   localparam int CTL_CFGS_BIT = 6;

   // ****
   // Widths and values
   // ****
   localparam int ADDR_W   = 15;
   localparam int DATA_W   = 14;
   localparam int LATCH_N  = 16;
   localparam int LATCH_AW = 4;
   localparam logic [DATA_W-1:0] ERASED_WORD = 14'h3FFF;
   localparam logic [7:0] KEY_FIRST  = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   localparam logic [1:0] WRT_OFF  = 2'h3;
   localparam logic [1:0] WRT_LOW  = 2'h2;
   localparam logic [1:0] WRT_HALF = 2'h1;

   // ****
   // Timing
   // ****
   localparam int CLK_MHZ     = 125;
   localparam int ERASE_US    = 2000;
   localparam int ERASE_CYC   = ERASE_US * CLK_MHZ;
   localparam int READ_CYC    = 2;

   // Sequencer states.
   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b000,
      ST_READ  = 3'b001,
      ST_ERASE = 3'b010,
      ST_PROG  = 3'b011,
      ST_CLEAR = 3'b100
   } pfw_state_type;

   // Unlock tracker states.
   typedef enum logic [1:0]
   {
      KY_NONE  = 2'b00,
      KY_FIRST = 2'b01,
      KY_OPEN  = 2'b10
   } pfw_key_type;

endpackage : pfw_pkg

// *** hw/pfw_timer.sv ***
// On-chip program/erase cycle timer for the flash self-write controller.
module pfw_timer
   import pfw_pkg::*;
#(
   parameter int CYCLES = ERASE_CYC
)
(
   input  wire logic ref_clk,  // System clock.
   input  wire logic sys_rst,  // Asynchronous reset, active high.
   input  wire logic start,    // Pulse that starts a timed cycle.
   output logic      done      // One-cycle pulse when the cycle ends.
);

   typedef struct packed
   {
      logic [31:0] cnt;
      logic        run;
      logic        done;
   } pfw_tmr_type;

   pfw_tmr_type cur_ff;
   pfw_tmr_type nxt_cur;

   // ****
   // Counter
   // ****
   // Timing is self-contained so firmware cannot shorten a cycle.
   always_comb
   begin
      nxt_cur      = cur_ff;
      nxt_cur.done = 1'b0;
      if (start)
      begin
         nxt_cur.run = 1'b1;
         nxt_cur.cnt = 32'(CYCLES - 1);
      end
      else if (cur_ff.run)
      begin
         if (cur_ff.cnt == 32'h0000_0000)
         begin
            nxt_cur.run  = 1'b0;
            nxt_cur.done = 1'b1;
         end
         else
         begin
            nxt_cur.cnt = cur_ff.cnt - 32'h0000_0001;
         end
      end
   end

   // State register.
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         cur_ff <= '0;
      else
         cur_ff <= nxt_cur;
   end

   assign done = cur_ff.done;

endmodule : pfw_timer

// *** sim/pfw_ctrl_props.sv ***
// Port-level assertions for the flash self-write controller.
module pfw_ctrl_chk
   import pfw_pkg::*;
#(
   parameter int ERASE_CYCLES = ERASE_CYC
)
(
   input logic        ref_clk,        // System clock.
   input logic        sys_rst,        // Async reset, active high.
   input logic        psel,           // APB select.
   input logic        penable,        // APB access phase.
   input logic        pwrite,         // APB direction.
   input logic [7:0]  paddr,          // APB byte address.
   input logic [31:0] prdata,         // APB read data.
   input logic        pready,         // APB ready.
   input logic        pslverr,        // APB error.
   input logic        code_protect_n, // Config, 0 = protected.
   input logic        cpu_stall,      // Core stalled by flash.
   input logic        ext_access_ok   // Programmer may access.
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Helper logic
   // ****
   // Length of the current stall, so a runaway timer cannot hide.
   int   stallLen_ff;
   logic rdAck;
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         stallLen_ff <= 0;
      else
         stallLen_ff <= cpu_stall ? stallLen_ff + 1 : 0;
   end
   // A read that completes at this edge.
   assign rdAck = pready && psel && !pwrite;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // ****
   // Assertions
   // ****
   AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered after one wait state");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   AST_ERR_MAP: assert property (
      pready |-> pslverr == (paddr > FLASH_CONFIG_OFS))
      else $error("error response does not match address map");
   AST_KEY_ZERO: assert property (
      rdAck && paddr == UNLOCK_KEY_OFS |-> prdata == 32'h0)
      else $error("unlock key read not zero");
   AST_DATA_WIDTH: assert property (
      rdAck && paddr == FLASH_DATA_HIGH_OFS |-> prdata[31:6] == '0)
      else $error("data high wider than the word");
   AST_ADDR_WIDTH: assert property (
      rdAck && paddr == FLASH_ADDR_HIGH_OFS |-> prdata[31:7] == '0)
      else $error("address high wider than 15 bits");
   AST_CP_BLOCKS: assert property (
      !code_protect_n [*4] |=> !ext_access_ok)
      else $error("programmer access open while protected");
   AST_TIMED_CYCLE: assert property (
      stallLen_ff <= ERASE_CYCLES + 8)
      else $error("stall outlasts the cycle timer");
   cover property (rdAck && paddr == UNLOCK_KEY_OFS);
   cover property (pslverr);
   cover property (cpu_stall [*8]);
endmodule : pfw_ctrl_chk

bind pfw_ctrl pfw_ctrl_chk #(.ERASE_CYCLES(ERASE_CYCLES)) chk_u (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .code_protect_n(code_protect_n), .cpu_stall(cpu_stall),
   .ext_access_ok(ext_access_ok));

// *** sim/pfw_host.sv ***
// Firmware-side model that drives the controller's APB port.
module pfw_host
   import pfw_pkg::*;
(
   input  logic        ref_clk, // System clock.
   output logic        psel,    // APB select.
   output logic        penable, // APB access phase.
   output logic        pwrite,  // APB direction.
   output logic [7:0]  paddr,   // APB byte address.
   output logic [31:0] pwdata,  // APB write data.
   input  logic [31:0] prdata,  // APB read data.
   input  logic        pready,  // APB ready.
   input  logic        pslverr  // APB error.
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Bus cycles
   // ****
   // Idle bus from time zero.
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // Held until ready; data inverted on release so it never looks valid.
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
      @(posedge ref_clk);
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      xfer(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      xfer(1'b0, a, 32'h0, r, e);
   endtask : rd
   // Low byte and high part of the word address.
   task automatic set_addr(input logic [14:0] a);
      wr(FLASH_ADDR_LOW_OFS, {24'h0, a[7:0]});
      wr(FLASH_ADDR_HIGH_OFS, {25'h0, a[14:8]});
   endtask : set_addr
   // Mode bits first, so nothing but the key sits between key and start.
   task automatic start(input logic [31:0] ctl);
      wr(FLASH_CONTROL_OFS, ctl & ~(32'h1 << CTL_WR_BIT));
      wr(UNLOCK_KEY_OFS, {24'h0, KEY_FIRST});
      wr(UNLOCK_KEY_OFS, {24'h0, KEY_SECOND});
      wr(FLASH_CONTROL_OFS, ctl);
   endtask : start
   // Firmware polls until hardware drops the start bit.
   task automatic poll(input int bitn);
      logic [31:0] r;
      do rd(FLASH_CONTROL_OFS, r); while (r[bitn] !== 1'b0);
   endtask : poll
endmodule : pfw_host

// *** sim/pfw_testbench.sv ***
// Self-checking testbench for the flash self-write controller.
module testbench
   import pfw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Design, host and clock
   // ****
   localparam logic [31:0] C_RD   = 32'h1 << CTL_RD_BIT;
   localparam logic [31:0] C_WR   = 32'h1 << CTL_WR_BIT;
   localparam logic [31:0] C_WRITE_ENABLE_GATE = 32'h1 << CTL_WRITE_ENABLE_GATE_BIT;
   localparam logic [31:0] C_FREE = 32'h1 << CTL_FREE_BIT;
   localparam logic [31:0] C_LWLO = 32'h1 << CTL_LWLO_BIT;
   localparam logic [14:0] ROW    = 15'h0700;
   logic        ref_clk, sys_rst, porN, cpN, psel, penable, pwrite;
   logic        pready, pslverr, cpuStall, extOk, bulkEr;
   logic [1:0]  wrtRegion;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   int          failures, checks_done;
   // Short cycle timer keeps each erase to 20 cycles.
   pfw_ctrl #(.ERASE_CYCLES(20)) dut_u (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .por_n(porN), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .code_protect_n(cpN),
      .write_protect_region(wrtRegion), .prog_bulk_erase(bulkEr),
      .cpu_stall(cpuStall), .ext_access_ok(extOk));
   pfw_host host_u (
      .ref_clk(ref_clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // 125 MHz clock.
   always #4 ref_clk = ~ref_clk;
   // ****
   // Checking and flash helpers
   // ****
   task automatic chk(input logic [31:0] got, exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: %s got %h", $time, what, got);
      end
   endtask : chk
   task automatic stop_test();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   task automatic expect_word(input logic [14:0] a, input logic [13:0] w);
      logic [31:0] lo, hi;
      host_u.set_addr(a);
      host_u.wr(FLASH_CONTROL_OFS, C_RD);
      host_u.poll(CTL_RD_BIT);
      host_u.rd(FLASH_DATA_LOW_OFS, lo);
      host_u.rd(FLASH_DATA_HIGH_OFS, hi);
      chk({18'h0, hi[5:0], lo[7:0]}, {18'h0, w}, "array word");
   endtask : expect_word
   task automatic ld_latch(input logic [14:0] a, input logic [13:0] w);
      host_u.set_addr(a);
      host_u.wr(FLASH_DATA_LOW_OFS, {24'h0, w[7:0]});
      host_u.wr(FLASH_DATA_HIGH_OFS, {26'h0, w[13:8]});
      host_u.start(C_WRITE_ENABLE_GATE | C_LWLO | C_WR);
      host_u.poll(CTL_WR_BIT);
   endtask : ld_latch
   task automatic commit(input logic [14:0] a, input logic [31:0] ctl);
      host_u.set_addr(a);
      host_u.start(ctl);
      host_u.poll(CTL_WR_BIT);
   endtask : commit
   // ****
   // Scenarios
   // ****
   task automatic t_regs();
      logic [31:0] r;
      logic        e;
      host_u.wr(UNLOCK_KEY_OFS, {24'h0, KEY_FIRST});
      host_u.rd(UNLOCK_KEY_OFS, r);
      chk(r, 32'h0, "key read");
      host_u.xfer(1'b0, 8'h1C, 32'h0, r, e);
      chk({31'h0, e}, 32'h1, "unmapped error");
      host_u.wr(FLASH_ADDR_HIGH_OFS, 32'hFFFFFFFF);
      host_u.rd(FLASH_ADDR_HIGH_OFS, r);
      chk(r, 32'h7F, "address high");
      host_u.wr(FLASH_DATA_HIGH_OFS, 32'hFFFFFFFF);
      host_u.rd(FLASH_DATA_HIGH_OFS, r);
      chk(r, 32'h3F, "data high");
      $display("test regs done");
   endtask : t_regs
   // Erase, two programs into one row, then latches back to erased.
   task automatic t_program();
      commit(ROW + 15'h3, C_WRITE_ENABLE_GATE | C_FREE | C_WR);
      expect_word(ROW + 15'hF, ERASED_WORD);
      ld_latch(ROW + 15'h2, 14'h1234);
      ld_latch(ROW + 15'h5, 14'h2ABC);
      commit(ROW + 15'h9, C_WRITE_ENABLE_GATE | C_WR);
      expect_word(ROW + 15'h5, 14'h2ABC);
      expect_word(ROW + 15'h3, ERASED_WORD);
      ld_latch(ROW + 15'h7, 14'h0555);
      commit(ROW, C_WRITE_ENABLE_GATE | C_WR);
      expect_word(ROW + 15'h7, 14'h0555);
      expect_word(ROW + 15'h2, 14'h1234);
      commit(ROW, C_WRITE_ENABLE_GATE | C_FREE | C_WR);
      commit(ROW, C_WRITE_ENABLE_GATE | C_WR);
      expect_word(ROW + 15'h7, ERASED_WORD);
      $display("test program done");
   endtask : t_program
   // Three refused starts must leave array and latch alone.
   task automatic t_refuse();
      ld_latch(ROW + 15'h9, 14'h0000);
      host_u.wr(FLASH_CONTROL_OFS, C_WRITE_ENABLE_GATE | C_WR);
      host_u.poll(CTL_WR_BIT);
      commit(ROW, C_WR);
      wrtRegion <= 2'h0;
      commit(ROW, C_WRITE_ENABLE_GATE | C_WR);
      wrtRegion <= WRT_OFF;
      expect_word(ROW + 15'h9, ERASED_WORD);
      commit(ROW, C_WRITE_ENABLE_GATE | C_WR);
      expect_word(ROW + 15'h9, 14'h0000);
      $display("test refuse done");
   endtask : t_refuse
   // Reset during an erase of another row, then power-up and protection.
   task automatic t_abort();
      logic [31:0] r;
      commit(ROW + 15'h10, C_WRITE_ENABLE_GATE | C_FREE | C_WR);
      host_u.set_addr(ROW + 15'h10);
      host_u.start(C_WRITE_ENABLE_GATE | C_FREE | C_WR);
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      host_u.rd(FLASH_CONTROL_OFS, r);
      chk({31'h0, r[CTL_WERR_BIT]}, 32'h1, "abort flag");
      host_u.wr(FLASH_CONTROL_OFS, C_WRITE_ENABLE_GATE);
      porN <= 1'b0;
      repeat (2) @(posedge ref_clk);
      porN <= 1'b1;
      @(posedge ref_clk);
      host_u.rd(FLASH_CONTROL_OFS, r);
      chk({31'h0, r[CTL_WRITE_ENABLE_GATE_BIT]}, 32'h0, "gate at power-up");
      cpN <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk({31'h0, extOk}, 32'h0, "programmer blocked");
      expect_word(ROW + 15'h9, 14'h0000);
      cpN <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk({31'h0, extOk}, 32'h0, "protect latched");
      bulkEr <= 1'b1;
      repeat (4) @(posedge ref_clk);
      bulkEr <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk({31'h0, extOk}, 32'h1, "programmer open");
      expect_word(ROW + 15'h9, ERASED_WORD);
      $display("test abort done");
   endtask : t_abort
   // Power-up reset for five cycles, then the scenarios in order.
   initial
   begin
      ref_clk = 1'b0;
      sys_rst = 1'b1;
      porN = 1'b0;
      cpN = 1'b1;
      bulkEr = 1'b0;
      wrtRegion = WRT_OFF;
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      porN <= 1'b1;
      @(posedge ref_clk);
      t_regs();
      t_program();
      t_refuse();
      t_abort();
      stop_test();
   end
   // A hang is cut short well beyond the expected run of under a thousand cycles.
   initial
   begin
      repeat (40000) @(posedge ref_clk);
      failures++;
      $display("CHECK FAILED at %0t: timeout", $time);
      stop_test();
   end
endmodule : testbench
